// File: dv/sult_loop_model.sv
`timescale 1ns/100ps
module sult_loop_model #(
  parameter int unsigned IdleCycles = 250_000_000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // scenario knobs
  input wire logic [5:0] lat,
  input wire logic [7:0] flip,
  // line character arriving with no send behind it
  input wire logic inject,
  // tester side
  input wire logic [7:0] txData,
  input wire logic txAck,
  input wire logic rxAck,
  output logic txOutputRequest,
  output logic txSerialOut,
  output logic [7:0] rxData,
  output logic rxInputReady,
  output logic rxCharLost,
  output logic rxLineBreak,
  output logic rxIdle
);
  logic [7:0] sent;
  logic [7:0] held;
  logic [5:0] cnt;
  logic [27:0] quiet;
  assign txOutputRequest = cnt == 6'h00;
  assign txSerialOut = cnt == 6'h00 ? 1'b1 : sent[cnt[2:0]];
  // released data lines must not look like the last character
  assign rxData = rxInputReady ? held : ~held;
  assign rxIdle = quiet >= IdleCycles;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sent <= 8'h00;
      held <= 8'h00;
      cnt <= 6'h00;
      quiet <= 28'h000_0000;
      rxInputReady <= 1'b0;
      rxCharLost <= 1'b0;
      rxLineBreak <= 1'b0;
    end else begin
      if (!rxIdle) quiet <= quiet + 28'h000_0001;
      if (rxAck) rxInputReady <= 1'b0;
      if (txAck && cnt == 6'h00) begin
        sent <= txData;
        cnt <= lat;
      end else if (cnt == 6'h01 || (inject && cnt == 6'h00)) begin
        cnt <= 6'h00;
        quiet <= 28'h000_0000;
        held <= sent ^ flip;
        rxInputReady <= 1'b1;
        rxCharLost <= rxInputReady && !rxAck;
        rxLineBreak <= (sent ^ flip) == 8'h00;
      end else if (cnt != 6'h00) begin
        cnt <= cnt - 6'h01;
      end
    end
  end
endmodule

// File: dv/tb_sult_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_sult_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] modeSel = 2'h0;
  logic [2:0] rateSel = 3'h0;
  logic [1:0] charLenSel = 2'h0;
  logic [7:0] patternSwitches = 8'h00;
  logic manualAcknowledgeButton = 1'b0;
  logic manualClear = 1'b0;
  logic tapeReaderInput = 1'b0;
  logic [5:0] lat = 6'h08;
  logic [7:0] flip = 8'h00;
  logic inject = 1'b0;
  logic [7:0] rxData, txData, bitLamps;
  logic rxInputReady, rxCharLost, rxLineBreak, rxIdle, rxSerialIn, rxAck;
  logic txOutputRequest, txSerialOut, txAck, lostLamp, breakLamp;
  logic failLamp, idleLamp, clockLamp, printMonitor;
  int n_fail = 0;
  int check_count = 0;
  int sends = 0;
  always #10 clk = ~clk;
  sult_top #(.BaseCycles(20)) i_sult_top (
    .clk, .arst_n, .modeSel, .rateSel, .charLenSel, .patternSwitches,
    .manualAcknowledgeButton, .manualClear, .rxData, .rxInputReady,
    .rxCharLost, .rxLineBreak, .rxIdle, .rxSerialOut(1'b1),
    .tapeReaderInput, .rxSerialIn, .rxAck, .txOutputRequest, .txSerialOut,
    .txData, .txAck, .bitLamps, .lostLamp, .breakLamp, .failLamp,
    .idleLamp, .clockLamp, .printMonitor);
  sult_loop_model #(.IdleCycles(300)) i_sult_loop_model (
    .clk, .arst_n, .lat, .flip, .inject, .txData, .txAck, .rxAck,
    .txOutputRequest,
    .txSerialOut, .rxData, .rxInputReady, .rxCharLost, .rxLineBreak,
    .rxIdle);
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // bounded: running out of cycles ends the run
  task automatic wait_on(input bit ack, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while ((ack ? rxAck : txOutputRequest) !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      n_fail++;
      $display("BAD wait exp 1 got 0");
      results();
    end
  endtask
  task automatic press();
    int n;
    n = 0;
    manualAcknowledgeButton = 1'b1;
    repeat (12) begin
      tick(1);
      n += int'(rxAck === 1'b1);
      sends += int'(txAck === 1'b1);
    end
    manualAcknowledgeButton = 1'b0;
    tick(2);
    `CHK("ack count", 1, n)
  endtask
  task automatic clr();
    manualClear = 1'b1;
    tick(1);
    manualClear = 1'b0;
    tick(2);
  endtask
  task automatic alt(input logic [1:0] len, input logic [7:0] a, b);
    logic [7:0] c;
    int n;
    modeSel = sult_pkg::ModeAlt;
    charLenSel = len;
    wait_on(0, n);
    clr();
    c = txData;
    `CHK("alt first", 1'b1, c === a || c === b)
    repeat (3) begin
      press();
      `CHK("alt next", c === a ? b : a, txData)
      wait_on(0, n);
      `CHK("lamps", c, bitLamps)
      c = txData;
    end
    `CHK("loop fail", 1'b0, failLamp)
  endtask
  task automatic refuse();
    logic [7:0] c;
    int n;
    int s;
    lat = 6'h1E;
    s = sends;
    press();
    `CHK("sent one", s + 1, sends)
    c = txData;
    press();
    `CHK("held char", c, txData)
    `CHK("refused send", s + 1, sends)
    lat = 6'h08;
    wait_on(0, n);
  endtask
  task automatic fails();
    int n;
    charLenSel = sult_pkg::Len5;
    flip = 8'h80;
    press();
    wait_on(0, n);
    flip = 8'h01;
    press();
    `CHK("upper bit", 1'b0, failLamp)
    flip = 8'h00;
    wait_on(0, n);
    press();
    `CHK("bad char", 1'b1, failLamp)
    wait_on(0, n);
    press();
    `CHK("fail held", 1'b1, failLamp)
    modeSel = sult_pkg::ModeTape;
    tapeReaderInput = 1'b1;
    tick(3);
    `CHK("tape fail", 1'b0, failLamp)
    `CHK("tape line", 1'b1, rxSerialIn)
    `CHK("tape data", sult_pkg::CharR, txData)
    modeSel = sult_pkg::ModeAlt;
    clr();
  endtask
  task automatic manual();
    logic p;
    int n;
    modeSel = sult_pkg::ModeSwitch;
    patternSwitches = 8'hA5;
    lat = 6'h1E;
    tick(3);
    `CHK("switches", 8'hA5, txData)
    rateSel = sult_pkg::Rate1050;
    repeat (60) begin
      p = txSerialOut;
      tick(1);
      `CHK("loop line", p, rxSerialIn)
      `CHK("monitor", p, printMonitor)
    end
    rateSel = sult_pkg::RateOff;
    patternSwitches = 8'h00;
    lat = 6'h08;
    wait_on(0, n);
    press();
    wait_on(0, n);
    `CHK("break", 1'b1, breakLamp)
    patternSwitches = 8'hA5;
    press();
    wait_on(0, n);
    `CHK("break held", 1'b1, breakLamp)
    clr();
    `CHK("break clear", 1'b0, breakLamp)
    inject = 1'b1;
    tick(1);
    inject = 1'b0;
    tick(2);
    `CHK("lost", 1'b1, lostLamp)
  endtask
  task automatic pacing();
    int n;
    logic [2:0] r[4] = '{sult_pkg::Rate1050, sult_pkg::Rate150,
                         sult_pkg::Rate100, sult_pkg::Rate75};
    int e[4] = '{20, 140, 200, 280};
    modeSel = sult_pkg::ModeAlt;
    clr();
    for (int i = 0; i < 4; i++) begin
      rateSel = r[i];
      wait_on(1, n);
      wait_on(1, n);
      `CHK("pace period", e[i], n)
      `CHK("clock lamp", 1'b1, clockLamp)
    end
    rateSel = sult_pkg::RateOff;
    n = 0;
    repeat (400) begin
      tick(1);
      n += int'(rxAck === 1'b1);
    end
    `CHK("off acks", 0, n)
    `CHK("clock off", 1'b0, clockLamp)
    `CHK("idle", 1'b1, idleLamp)
    `CHK("paced fail", 1'b0, failLamp)
    clr();
    `CHK("lost clear", 1'b0, lostLamp)
  endtask
  initial begin
    tick(3);
    arst_n = 1'b1;
    tick(1);
    for (int l = 0; l < 4; l++) begin
      alt(2'(l), l == 0 ? sult_pkg::CharR : sult_pkg::CharJ,
          l == 0 ? sult_pkg::CharY : sult_pkg::Char5);
    end
    refuse();
    fails();
    manual();
    pacing();
    results();
  end
endmodule

// File: hdl/sult_pacer.sv
`timescale 1ns/100ps
module sult_pacer #(
  parameter int unsigned BaseCycles = sult_pkg::BaseCycles
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] rateSel,
  output logic pacePulse
);
  sult_pkg::sult_pace_t st_r, st_nxt;
  logic [3:0] divLimit;

  always_comb begin
    case (rateSel)
      sult_pkg::Rate150: divLimit = sult_pkg::Div150;
      sult_pkg::Rate100: divLimit = sult_pkg::Div100;
      sult_pkg::Rate75: divLimit = sult_pkg::Div75;
      default: divLimit = 4'h1;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.basePulse = 1'b0;
    if (rateSel == sult_pkg::RateOff || rateSel > sult_pkg::Rate75) begin
      // stopped: base clock held, no pulses
      st_nxt.baseCnt = '0;
      st_nxt.divCnt = '0;
    end else if (st_r.baseCnt == 19'(BaseCycles - 1)) begin
      st_nxt.baseCnt = '0;
      // pass only the first base pulse of each group
      st_nxt.basePulse = (st_r.divCnt == 4'h0);
      st_nxt.divCnt = (st_r.divCnt + 4'h1 >= divLimit) ? 4'h0
                      : st_r.divCnt + 4'h1;
    end else begin
      st_nxt.baseCnt = st_r.baseCnt + 19'h0_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pacePulse = st_r.basePulse;

  pace_stop_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rateSel == sult_pkg::RateOff |=> !pacePulse)
    else $error("pacer pulsed while off");
  pace_spacing_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    pacePulse |=> !pacePulse [*8])
    else $error("pace pulses too close");
endmodule

// File: hdl/sult_pkg.sv
package sult_pkg;
  // pacing
  localparam int unsigned ClkHz = 50_000_000;
  localparam int unsigned BasePeriodUs = 9000;
  localparam int unsigned BaseCycles = (BasePeriodUs * 50);
  localparam int unsigned BaseCntW = 19;
  localparam logic [3:0] Div150 = 4'h7;
  localparam logic [3:0] Div100 = 4'hA;
  localparam logic [3:0] Div75 = 4'hE;
  // rate selector codes
  localparam logic [2:0] RateOff = 3'h0;
  localparam logic [2:0] Rate1050 = 3'h1;
  localparam logic [2:0] Rate150 = 3'h2;
  localparam logic [2:0] Rate100 = 3'h3;
  localparam logic [2:0] Rate75 = 3'h4;
  // mode codes
  localparam logic [1:0] ModeSwitch = 2'h0;
  localparam logic [1:0] ModeAlt = 2'h1;
  localparam logic [1:0] ModeTape = 2'h2;
  // character length codes: 0=5,1=6,2=7,3=8 bits
  localparam logic [1:0] Len5 = 2'h0;
  // alternating test characters
  localparam logic [7:0] CharR = 8'h0A;
  localparam logic [7:0] CharY = 8'h15;
  localparam logic [7:0] CharJ = 8'h4A;
  localparam logic [7:0] Char5 = 8'h35;
  localparam logic [7:0] ZeroChar = 8'h00;

  typedef struct packed {
    logic [18:0] baseCnt;
    logic [3:0] divCnt;
    logic basePulse;
  } sult_pace_t;
endpackage

// File: hdl/sult_top.sv
// What this block does
// - generator alternates two characters of alternating ones and zeros.
// - fail check active whenever generator runs; flags wrong returned char.
// - clear input resets lost, break and fail flags; otherwise they latch, except fail in tape mode.
// - outside tape mode transmit serial output feeds receive serial input.
// - switch-pattern mode drives transmit data from eight pattern switches.
// - rates 1050, 150, 100, 75 wpm or off; off means manual acks only.
// - bit indicators show received character until next one is sent.
// - length selects 5 to 8 bits; unused upper bits ignored in checks.
// - alternate R/Y at five bits, J/5 at six to eight bits.
// - alternating mode compares returned char and sets fail on mismatch.
// - each manual ack that meets an output request advances generator one character in alternating mode.
// - tape mode passes received characters straight to transmit unit.
// - with rate off pacing clock stops; clock indicator shows pulsing.
// - base pacing pulse every 9 ms, used undivided at 1050 wpm.
// - divide base by 7, 10 or 14 for 150, 100 and 75 wpm.
// - generator toggles only when ack coincides with output request.
// - fail flag held clear while tape mode is selected.
`timescale 1ns/100ps
module sult_top #(
  parameter int unsigned BaseCycles = sult_pkg::BaseCycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // panel controls
  input wire logic [1:0] modeSel,
  input wire logic [2:0] rateSel,
  input wire logic [1:0] charLenSel,
  input wire logic [7:0] patternSwitches,
  input wire logic manualAcknowledgeButton,
  input wire logic manualClear,
  // serial pair: receive unit
  input wire logic [7:0] rxData,
  input wire logic rxInputReady,
  input wire logic rxCharLost,
  input wire logic rxLineBreak,
  input wire logic rxIdle,
  input wire logic rxSerialOut,
  input wire logic tapeReaderInput,
  output logic rxSerialIn,
  output logic rxAck,
  // serial pair: transmit unit
  input wire logic txOutputRequest,
  input wire logic txSerialOut,
  output logic [7:0] txData,
  output logic txAck,
  // indicators
  output logic [7:0] bitLamps,
  output logic lostLamp,
  output logic breakLamp,
  output logic failLamp,
  output logic idleLamp,
  output logic clockLamp,
  output logic printMonitor
);
  typedef struct packed {
    logic ackSync1;
    logic ackSync2;
    logic ackPrev;
    logic genSel;
    logic [7:0] sentChar;
    logic sentValid;
    logic [7:0] txData;
    logic txAck;
    logic rxAck;
    logic rxSerialIn;
    logic [7:0] bitLamps;
    logic lost;
    logic brk;
    logic fail;
    logic idle;
    logic clockRun;
    logic monitor;
  } sult_state_t;

  sult_state_t st_r, st_nxt;
  logic pacePulse;
  logic manualStrobe;
  logic ackEvent;
  logic tapeMode;
  logic altMode;
  logic rateOff;

  // upper bits beyond the selected length forced to zero
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    return 8'hFF >> (3'h3 - 3'(len));
  endfunction

  function automatic logic [7:0] alt_char(input logic [1:0] len,
                                          input logic sel);
    if (len == sult_pkg::Len5) begin
      return sel ? sult_pkg::CharY : sult_pkg::CharR;
    end
    return sel ? sult_pkg::Char5 : sult_pkg::CharJ;
  endfunction

  sult_pacer #(.BaseCycles(BaseCycles)) u_pacer (
    .clk(clk),
    .arst_n(arst_n),
    .rateSel(rateSel),
    .pacePulse(pacePulse)
  );

  assign tapeMode = (modeSel == sult_pkg::ModeTape);
  assign altMode = (modeSel == sult_pkg::ModeAlt);
  // unused selector codes stop the pacer, so the lamp must drop too
  assign rateOff = (rateSel == sult_pkg::RateOff) ||
                   (rateSel > sult_pkg::Rate75);
  // one strobe per press, second stage only feeds the edge detector
  assign manualStrobe = st_r.ackSync2 & ~st_r.ackPrev;
  // manual and paced acks both accepted
  assign ackEvent = pacePulse | manualStrobe;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ackSync1 = manualAcknowledgeButton;
    st_nxt.ackSync2 = st_r.ackSync1;
    st_nxt.ackPrev = st_r.ackSync2;
    st_nxt.txAck = 1'b0;
    st_nxt.rxAck = 1'b0;
    st_nxt.clockRun = pacePulse ? 1'b1 : (rateOff ? 1'b0 : st_r.clockRun);
    // loop closed unless tape input selected
    st_nxt.rxSerialIn = tapeMode ? tapeReaderInput : txSerialOut;
    st_nxt.monitor = txSerialOut;
    st_nxt.idle = rxIdle;
    case (modeSel)
      sult_pkg::ModeSwitch: begin
        st_nxt.txData = patternSwitches;
      end
      sult_pkg::ModeAlt: begin
        // alternating ones/zeros pattern
        st_nxt.txData = alt_char(charLenSel, st_r.genSel);
      end
      sult_pkg::ModeTape: begin
        if (rxInputReady) begin
          st_nxt.txData = rxData;
        end
      end
      default: begin
        st_nxt.txData = patternSwitches;
      end
    endcase
    if (ackEvent) begin
      st_nxt.rxAck = 1'b1;
      if (txOutputRequest) begin
        st_nxt.txAck = 1'b1;
        // kept whole: length may change between send and return
        st_nxt.sentChar = st_r.txData;
        st_nxt.sentValid = 1'b1;
        // toggle only on ack with request: no repeated char
        if (altMode) begin
          st_nxt.genSel = ~st_r.genSel;
        end
      end
    end
    // lamps hold received char until next send
    if (rxInputReady && !(ackEvent && txOutputRequest)) begin
      st_nxt.bitLamps = rxData;
    end
    // latched flags; clear loses to a new event
    if (manualClear) begin
      st_nxt.lost = 1'b0;
      st_nxt.brk = 1'b0;
      st_nxt.fail = 1'b0;
    end
    if (rxCharLost) begin
      st_nxt.lost = 1'b1;
    end
    if (rxLineBreak) begin
      st_nxt.brk = 1'b1;
    end
    if (altMode && rxInputReady && ackEvent && st_r.sentValid &&
        (((rxData ^ st_r.sentChar) & len_mask(charLenSel)) != 8'h00)) begin
      st_nxt.fail = 1'b1;
    end
    if (tapeMode) begin
      st_nxt.fail = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rxSerialIn = st_r.rxSerialIn;
  assign rxAck = st_r.rxAck;
  assign txData = st_r.txData;
  assign txAck = st_r.txAck;
  assign bitLamps = st_r.bitLamps;
  assign lostLamp = st_r.lost;
  assign breakLamp = st_r.brk;
  assign failLamp = st_r.fail;
  assign idleLamp = st_r.idle;
  assign clockLamp = st_r.clockRun;
  assign printMonitor = st_r.monitor;

  gen_toggle_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    altMode && ackEvent && txOutputRequest
    |=> st_r.genSel != $past(st_r.genSel))
    else $error("generator did not toggle");
  gen_hold_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !(ackEvent && txOutputRequest) |=> $stable(st_r.genSel))
    else $error("generator changed without ack");
  fail_latch_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    failLamp && !manualClear && !tapeMode |=> failLamp)
    else $error("fail flag dropped");
  lost_latch_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rxCharLost |=> lostLamp)
    else $error("lost not latched");
  tape_fail_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    tapeMode |=> !failLamp)
    else $error("fail set in tape mode");
  loop_route_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !tapeMode |=> rxSerialIn == $past(txSerialOut))
    else $error("loop not closed");
  switch_data_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    modeSel == sult_pkg::ModeSwitch
    |=> txData == $past(patternSwitches))
    else $error("switch pattern not driven");
  one_strobe_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    manualStrobe |=> !manualStrobe)
    else $error("manual strobe too long");

  alt_send_c: cover property (@(posedge clk) altMode && txAck);
  fail_seen_c: cover property (@(posedge clk) $rose(failLamp));
  tape_pass_c: cover property (@(posedge clk) tapeMode && rxInputReady);
  manual_ack_c: cover property (@(posedge clk) manualStrobe);
endmodule
